// ### verilog/rhdlc_map.svh
`ifndef RHDLC_MAP_SVH
`define RHDLC_MAP_SVH
// ******************************
// header forms
// ******************************
`define RHDLC_HDR_NONE 3'h0
`define RHDLC_HDR_A1 3'h1
`define RHDLC_HDR_A2 3'h2
`define RHDLC_HDR_A1C 3'h3
`define RHDLC_HDR_A2C 3'h4
// ******************************
// framing and crc
// ******************************
`define RHDLC_FLAG 8'h7E
`define RHDLC_ESC 8'h7D
`define RHDLC_ESC_XOR 8'h20
`define RHDLC_CRC_INIT 16'hFFFF
`define RHDLC_CRC_POLY 16'h8408
`define RHDLC_ONES_MAX 3'h5
// ******************************
// policing
// ******************************
`define RHDLC_FILL_FRAC 6
`define RHDLC_RATE_UNIT 13'h0100
`define RHDLC_DESC_LEN 2
`endif

// ### verilog/rhdlc_pkg.sv
package rhdlc_pkg;
   typedef enum logic [3:0] {
      RH_IDLE, RH_POLICE, RH_HDR, RH_BODY, RH_CRC, RH_CLOSE, RH_FETCH, RH_CHECK,
      RH_WRITE, RH_DESC, RH_WPTR, RH_EVENT, RH_DROP
   } rhdlc_state_e;
   typedef logic [8:0] rhdlc_stream_t;
   typedef logic [15:0] rhdlc_ptr_t;
endpackage : rhdlc_pkg

// ### verilog/rhdlc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module rhdlc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign count = wp - rp;
   assign out_data = mem[rp[AW-1:0]];
   always_ff @(posedge clk) begin
      if (do_wr) mem[wp[AW-1:0]] <= in_data;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
      end else if (clear) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (do_wr) wp <= wp + 1'b1;
         if (do_rd) rp <= rp + 1'b1;
      end
   end
endmodule : rhdlc_fifo
`default_nettype wire

// ### verilog/rhdlc_crc.sv
`timescale 1ns/10ps
`default_nettype none
`include "rhdlc_map.svh"
module rhdlc_crc (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic init,
   input wire logic step,
   input wire logic [7:0] data,
   output logic [15:0] fcs
);
   logic [15:0] crc;
   logic [15:0] next_crc;
   always_comb begin
      next_crc = crc;
      for (int i = 0; i < 8; i++) begin
         if (next_crc[0] ^ data[i]) next_crc = (next_crc >> 1) ^ `RHDLC_CRC_POLY;
         else next_crc = next_crc >> 1;
      end
   end
   // transmitted fcs is the ones complement, low byte first
   assign fcs = ~crc;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) crc <= `RHDLC_CRC_INIT;
      else if (init) crc <= `RHDLC_CRC_INIT;
      else if (step) crc <= next_crc;
   end
endmodule : rhdlc_crc
`default_nettype wire

// ### verilog/rhdlc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rhdlc_map.svh"
module rhdlc_top #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   // packet payload in, bytes with last marker
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire logic [7:0] pkt_data,
   input wire logic pkt_last,
   input wire logic [15:0] pkt_len,
   input wire logic [15:0] pkt_seq,
   input wire logic [31:0] pkt_tstamp,
   input wire logic [15:0] frame_now,
   // channel structure fields
   input wire rhdlc_pkg::rhdlc_stream_t stream_num,
   input wire logic [11:0] buffer_index,
   input wire logic [2:0] header_form,
   input wire logic crc_enable,
   input wire logic framing_select,
   input wire logic always_report_enable,
   input wire logic recover_a,
   input wire logic recover_b,
   input wire logic [7:0] hdlc_address0,
   input wire logic [7:0] hdlc_address1,
   input wire logic [7:0] hdlc_control,
   input wire logic [1:0] rate_mantissa,
   input wire logic [3:0] rate_exponent,
   input wire logic [15:0] max_bucket_fill,
   input wire logic [31:0] current_bucket_level,
   input wire logic [15:0] last_frame,
   input wire logic [15:0] rx_packet_count,
   input wire logic [31:0] rx_byte_count,
   // channel write-back
   output logic chan_wb,
   output logic [31:0] next_bucket_level,
   output logic [15:0] next_last_frame,
   output logic [15:0] next_packet_count,
   output logic [31:0] next_byte_count,
   // stream control table port
   output logic ctl_rd,
   output logic [11:0] ctl_index,
   input wire logic ctl_ack,
   input wire rhdlc_pkg::rhdlc_ptr_t ctl_base,
   input wire rhdlc_pkg::rhdlc_ptr_t ctl_rptr,
   input wire rhdlc_pkg::rhdlc_ptr_t ctl_wptr,
   input wire rhdlc_pkg::rhdlc_ptr_t ctl_size,
   output logic ctl_wr,
   output rhdlc_pkg::rhdlc_ptr_t ctl_new_wptr,
   // circular buffer writes
   output logic buf_we,
   output logic [15:0] buf_addr,
   output logic [7:0] buf_data,
   // descriptor to stream queue
   output logic desc_valid,
   output rhdlc_pkg::rhdlc_stream_t desc_stream,
   output logic [15:0] desc_addr,
   output logic [15:0] desc_len,
   // event report and recovery queues
   output logic event_valid,
   output logic event_police_err,
   output logic event_nospace,
   output logic reca_valid,
   output logic recb_valid,
   output logic [47:0] rec_data
);
   import rhdlc_pkg::*;
   // ******************************
   // reset release
   // ******************************
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end
   // ******************************
   // state and captured channel
   // ******************************
   rhdlc_state_e state;
   logic [2:0] hdr_idx;
   logic [15:0] fr_len;
   logic [15:0] wr_cnt;
   logic [15:0] wptr;
   logic [31:0] disch_fill;
   logic crc_phase;
   logic [2:0] ones;
   logic [23:0] bit_acc;
   logic [4:0] bit_cnt;
   logic esc_pend;
   logic [7:0] esc_byte;
   // table fields only stand with the answer, so they are held here
   rhdlc_ptr_t tbl_base;
   rhdlc_ptr_t tbl_size;
   logic room_ok;
   // ******************************
   // policing arithmetic
   // ******************************
   wire [15:0] elapsed = frame_now - last_frame;
   // rate in 1/64 byte per frame: base 1/16 scaled by 1.mm and exponent
   wire [2:0] mant = {1'b1, rate_mantissa};
   wire [31:0] rate64 = 32'(mant) << rate_exponent;
   wire [47:0] disch = 48'(elapsed) * 48'(rate64);
   wire [47:0] fill48 = 48'(current_bucket_level);
   wire [31:0] after_disch = (disch >= fill48) ? 32'h0 : 32'(fill48 - disch);
   wire [16:0] max_bytes = (max_bucket_fill == 16'h0) ? 17'h10000 : 17'(max_bucket_fill);
   wire [31:0] max64 = 32'(max_bytes) << `RHDLC_FILL_FRAC;
   wire [31:0] add64 = 32'(pkt_len) << `RHDLC_FILL_FRAC;
   wire [32:0] sum64 = 33'(after_disch) + 33'(add64);
   wire police_fail = sum64 > 33'(max64);
   // ******************************
   // header byte selection
   // ******************************
   logic [2:0] hdr_n;
   always_comb begin
      case (header_form)
         `RHDLC_HDR_A1: hdr_n = 3'h1;
         `RHDLC_HDR_A2: hdr_n = 3'h2;
         `RHDLC_HDR_A1C: hdr_n = 3'h2;
         `RHDLC_HDR_A2C: hdr_n = 3'h3;
         default: hdr_n = 3'h0;
      endcase
   end
   wire two_addr = (header_form == `RHDLC_HDR_A2) || (header_form == `RHDLC_HDR_A2C);
   wire [7:0] hdr_byte = (hdr_idx == 3'h0) ? hdlc_address0 :
                         (hdr_idx == 3'h1 && two_addr) ? hdlc_address1 : hdlc_control;
   // ******************************
   // framer source bytes
   // ******************************
   logic [15:0] fcs;
   wire src_hdr = (state == RH_HDR);
   wire src_body = (state == RH_BODY);
   wire src_crc = (state == RH_CRC);
   wire [7:0] src_byte = src_hdr ? hdr_byte : src_body ? pkt_data : crc_phase ? fcs[15:8] : fcs[7:0];
   logic ff_in_ready;
   logic ff_out_valid;
   logic [8:0] ff_out;
   logic [$clog2(FIFO_DEPTH):0] ff_count;
   // one source byte per cycle when the framer is free and the fifo has room
   wire bit_full = (bit_cnt >= 5'h08);
   wire fr_busy = esc_pend || (framing_select == 1'b0 && bit_full);
   wire fr_done = !fr_busy && (framing_select || bit_cnt == 5'h00);
   wire src_take = (src_hdr || (src_body && pkt_valid) || src_crc) && !fr_busy && ff_in_ready;
   assign pkt_ready = src_body && !fr_busy && ff_in_ready;
   rhdlc_crc u_crc (
      .clk(clk),
      .rst_n(rst_n),
      .init(state == RH_POLICE),
      .step(src_take && !src_crc),
      .data(src_byte),
      .fcs(fcs)
   );
   // ******************************
   // framer: escaping or zero-bit stuffing
   // ******************************
   wire need_esc = (src_byte == `RHDLC_FLAG) || (src_byte == `RHDLC_ESC);
   logic ff_in_valid;
   logic [7:0] ff_in_data;
   always_comb begin
      ff_in_valid = 1'b0;
      ff_in_data = src_byte;
      if (framing_select) begin
         if (esc_pend) begin
            ff_in_valid = 1'b1;
            ff_in_data = esc_byte;
         end else if (src_take) begin
            ff_in_valid = 1'b1;
            ff_in_data = need_esc ? `RHDLC_ESC : src_byte;
         end
      end else begin
         ff_in_valid = bit_full;
         ff_in_data = bit_acc[7:0];
      end
   end
   // bit stuffing: append one input byte to the accumulator, inserting zeros
   // up to 17 bits may wait, so a byte only enters below 8 held bits
   logic [23:0] next_acc;
   logic [4:0] next_bcnt;
   logic [2:0] next_ones;
   always_comb begin
      next_acc = bit_acc;
      next_bcnt = bit_cnt;
      next_ones = ones;
      if (src_take && !framing_select) begin
         for (int i = 0; i < 8; i++) begin
            next_acc[next_bcnt] = src_byte[i];
            next_bcnt = next_bcnt + 5'h01;
            next_ones = src_byte[i] ? next_ones + 3'h1 : 3'h0;
            if (next_ones == `RHDLC_ONES_MAX) begin
               next_acc[next_bcnt] = 1'b0;
               next_bcnt = next_bcnt + 5'h01;
               next_ones = 3'h0;
            end
         end
      end
   end
   rhdlc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .clear(state == RH_DROP),
      .in_valid(ff_in_valid),
      .in_ready(ff_in_ready),
      .in_data({1'b0, ff_in_data}),
      .out_valid(ff_out_valid),
      .out_ready(state == RH_WRITE),
      .out_data(ff_out),
      .count(ff_count)
   );
   // ******************************
   // buffer room
   // ******************************
   wire [15:0] used = ctl_wptr - ctl_rptr;
   wire [15:0] room = ctl_size - used - 16'h1;
   wire has_room = fr_len <= room;
   // ******************************
   // main sequence
   // ******************************
   wire body_end = src_take && src_body && pkt_last;
   wire crc_end = src_take && src_crc && crc_phase;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= RH_IDLE;
         hdr_idx <= 3'h0;
         fr_len <= 16'h0;
         crc_phase <= 1'b0;
         esc_pend <= 1'b0;
         esc_byte <= 8'h0;
         disch_fill <= 32'h0;
         wr_cnt <= 16'h0;
         wptr <= 16'h0;
         bit_acc <= 24'h0;
         bit_cnt <= 5'h00;
         ones <= 3'h0;
         tbl_base <= 16'h0;
         tbl_size <= 16'h0;
         room_ok <= 1'b0;
      end else begin
         if (framing_select) begin
            esc_pend <= src_take && need_esc;
            esc_byte <= src_byte ^ `RHDLC_ESC_XOR;
         end else if (bit_full) begin
            if (ff_in_ready) begin
               bit_acc <= bit_acc >> 8;
               bit_cnt <= bit_cnt - 5'h08;
            end
         end else begin
            bit_acc <= next_acc;
            bit_cnt <= next_bcnt;
            ones <= next_ones;
         end
         if (ff_in_valid && ff_in_ready) fr_len <= fr_len + 16'h1;
         case (state)
            RH_IDLE: begin
               fr_len <= 16'h0;
               hdr_idx <= 3'h0;
               crc_phase <= 1'b0;
               bit_acc <= 24'h0;
               bit_cnt <= 5'h00;
               ones <= 3'h0;
               if (pkt_valid) state <= RH_POLICE;
            end
            RH_POLICE: begin
               disch_fill <= after_disch;
               if (police_fail) state <= RH_EVENT;
               else if (hdr_n == 3'h0) state <= RH_BODY;
               else state <= RH_HDR;
            end
            RH_HDR: begin
               if (src_take) hdr_idx <= hdr_idx + 3'h1;
               if (src_take && hdr_idx + 3'h1 == hdr_n) state <= RH_BODY;
            end
            RH_BODY: begin
               if (body_end) state <= crc_enable ? RH_CRC : RH_CLOSE;
            end
            RH_CRC: begin
               if (src_take) crc_phase <= 1'b1;
               if (crc_end) state <= RH_CLOSE;
            end
            RH_CLOSE: begin
               // flush partial stuffed byte padded with ones
               if (!framing_select && !fr_busy && bit_cnt != 5'h00) begin
                  bit_acc <= bit_acc | (24'hFFFFFF << bit_cnt);
                  bit_cnt <= 5'h08;
               end
               if (fr_done) state <= RH_FETCH;
            end
            RH_FETCH: begin
               if (ctl_ack) begin
                  wptr <= ctl_wptr;
                  tbl_base <= ctl_base;
                  tbl_size <= ctl_size;
                  room_ok <= has_room;
                  state <= RH_CHECK;
               end
            end
            RH_CHECK: begin
               wr_cnt <= 16'h0;
               state <= room_ok ? RH_WRITE : RH_DROP;
            end
            RH_WRITE: begin
               if (ff_out_valid) begin
                  wptr <= (wptr + 16'h1 == tbl_size) ? 16'h0 : wptr + 16'h1;
                  wr_cnt <= wr_cnt + 16'h1;
               end
               if (ff_out_valid && wr_cnt + 16'h1 == fr_len) state <= RH_DESC;
            end
            RH_DESC: state <= RH_WPTR;
            RH_WPTR: state <= RH_EVENT;
            RH_DROP: state <= RH_EVENT;
            RH_EVENT: state <= RH_IDLE;
            default: state <= RH_IDLE;
         endcase
      end
   end
   // ******************************
   // output registers
   // ******************************
   logic drop_flag;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_wb <= 1'b0;
         next_bucket_level <= 32'h0;
         next_last_frame <= 16'h0;
         next_packet_count <= 16'h0;
         next_byte_count <= 32'h0;
         ctl_rd <= 1'b0;
         ctl_index <= 12'h0;
         ctl_wr <= 1'b0;
         ctl_new_wptr <= 16'h0;
         buf_we <= 1'b0;
         buf_addr <= 16'h0;
         buf_data <= 8'h0;
         desc_valid <= 1'b0;
         desc_stream <= '0;
         desc_addr <= 16'h0;
         desc_len <= 16'h0;
         event_valid <= 1'b0;
         event_police_err <= 1'b0;
         event_nospace <= 1'b0;
         reca_valid <= 1'b0;
         recb_valid <= 1'b0;
         rec_data <= 48'h0;
         drop_flag <= 1'b0;
      end else begin
         chan_wb <= (state == RH_POLICE);
         if (state == RH_POLICE) begin
            next_bucket_level <= police_fail ? after_disch : 32'(sum64);
            next_last_frame <= frame_now;
            next_packet_count <= rx_packet_count + 16'h1;
            next_byte_count <= rx_byte_count + 32'(pkt_len);
            drop_flag <= police_fail;
            event_police_err <= police_fail;
            event_nospace <= 1'b0;
         end
         ctl_rd <= (state == RH_CLOSE) && fr_done;
         ctl_index <= buffer_index;
         buf_we <= (state == RH_WRITE) && ff_out_valid;
         buf_addr <= tbl_base + wptr;
         buf_data <= ff_out[7:0];
         desc_valid <= (state == RH_DESC);
         desc_stream <= stream_num;
         if (state == RH_FETCH && ctl_ack) desc_addr <= ctl_wptr;
         desc_len <= fr_len;
         ctl_wr <= (state == RH_WPTR);
         ctl_new_wptr <= wptr;
         if (state == RH_DROP) event_nospace <= 1'b1;
         event_valid <= (state == RH_EVENT) && (always_report_enable || event_police_err || event_nospace);
         reca_valid <= (state == RH_EVENT) && recover_a && !drop_flag;
         recb_valid <= (state == RH_EVENT) && recover_b && !drop_flag;
         rec_data <= {pkt_seq, pkt_tstamp};
      end
   end
   // a police drop leaves the payload unconsumed at the input, never taking it into the framer
   // descriptors feed the tdm drain logic outside; lives there
endmodule : rhdlc_top
`default_nettype wire

// ### test/rhdlc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rhdlc_assertions (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] pkt_seq,
   input wire logic [31:0] pkt_tstamp,
   input wire rhdlc_pkg::rhdlc_stream_t stream_num,
   input wire logic [11:0] buffer_index,
   input wire logic [15:0] rx_packet_count,
   input wire logic chan_wb,
   input wire logic [15:0] next_packet_count,
   input wire logic ctl_rd,
   input wire logic [11:0] ctl_index,
   input wire logic ctl_ack,
   input wire logic ctl_wr,
   input wire logic buf_we,
   input wire logic desc_valid,
   input wire rhdlc_pkg::rhdlc_stream_t desc_stream,
   input wire logic event_valid,
   input wire logic event_police_err,
   input wire logic event_nospace,
   input wire logic reca_valid,
   input wire logic recb_valid,
   input wire logic [47:0] rec_data
);
   import rhdlc_pkg::*;
   logic fetched;
   logic wrote;
   // ************
   // packet progress
   // ************
   // chan_wb opens every packet, so it clears what the last one left
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fetched <= 1'b0;
         wrote <= 1'b0;
      end else begin
         fetched <= !chan_wb && (fetched || ctl_ack);
         wrote <= !chan_wb && (wrote || buf_we);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_commit;
      desc_valid ##1 ctl_wr;
   endsequence
   chk_desc_stream: assert property (desc_valid |-> desc_stream == stream_num)
      else $error("descriptor stream wrong");
   chk_table_index: assert property (ctl_rd |-> ctl_index == buffer_index)
      else $error("table index wrong");
   chk_write_fetched: assert property (buf_we |-> fetched)
      else $error("buffer written before fetch");
   chk_desc_written: assert property (desc_valid |-> wrote)
      else $error("descriptor without data");
   chk_commit_order: assert property (desc_valid |-> s_commit)
      else $error("pointer not written after descriptor");
   chk_nospace_quiet: assert property (event_valid && event_nospace |-> !wrote && !$past(ctl_wr))
      else $error("no room but buffer touched");
   chk_police_drop: assert property (event_valid && event_police_err |-> !fetched && !wrote)
      else $error("dropped packet was stored");
   chk_pkt_count: assert property (chan_wb |-> next_packet_count == rx_packet_count + 16'h0001)
      else $error("packet count not stepped");
   chk_rec_fields: assert property (reca_valid || recb_valid |-> rec_data == {pkt_seq, pkt_tstamp})
      else $error("recovery event fields wrong");
endmodule : rhdlc_assertions
bind rhdlc_top rhdlc_assertions chk_u (.clk(clk), .nrst(nrst), .pkt_seq(pkt_seq), .pkt_tstamp(pkt_tstamp),
   .stream_num(stream_num), .buffer_index(buffer_index), .rx_packet_count(rx_packet_count), .chan_wb(chan_wb),
   .next_packet_count(next_packet_count), .ctl_rd(ctl_rd), .ctl_index(ctl_index), .ctl_ack(ctl_ack),
   .ctl_wr(ctl_wr), .buf_we(buf_we), .desc_valid(desc_valid), .desc_stream(desc_stream),
   .event_valid(event_valid), .event_police_err(event_police_err), .event_nospace(event_nospace),
   .reca_valid(reca_valid), .recb_valid(recb_valid), .rec_data(rec_data));
`default_nettype wire

// ### test/rhdlc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module rhdlc_partner (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ctl_rd,
   input wire logic ctl_wr,
   input wire rhdlc_pkg::rhdlc_ptr_t ctl_new_wptr,
   input wire logic [3:0] lag,
   input wire rhdlc_pkg::rhdlc_ptr_t room,
   output logic ctl_ack,
   output rhdlc_pkg::rhdlc_ptr_t ctl_base,
   output rhdlc_pkg::rhdlc_ptr_t ctl_rptr,
   output rhdlc_pkg::rhdlc_ptr_t ctl_wptr,
   output rhdlc_pkg::rhdlc_ptr_t ctl_size
);
   import rhdlc_pkg::*;
   logic busy;
   logic [3:0] cnt;
   rhdlc_ptr_t wp;
   // ************
   // control table entry
   // ************
   // reader keeps pace with the writer, so the buffer looks empty and room is one less than size
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         wp <= 16'h0000;
         ctl_ack <= 1'b0;
      end else begin
         busy <= ctl_rd || (busy && cnt != 4'h0);
         cnt <= ctl_rd ? lag : cnt - 4'h1;
         ctl_ack <= busy && cnt == 4'h0;
         if (ctl_wr) begin
            wp <= ctl_new_wptr;
         end
      end
   end
   // fields are only valid with the answer; otherwise show junk
   assign ctl_base = ctl_ack ? 16'h4000 : ~wp;
   assign ctl_rptr = ctl_ack ? wp : ~wp;
   assign ctl_wptr = ctl_ack ? wp : ~wp;
   assign ctl_size = ctl_ack ? room : ~room;
endmodule : rhdlc_partner
`default_nettype wire

// ### test/rhdlc_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rhdlc_top_tb_top;
   import rhdlc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, pkt_valid = 1'b0, pkt_last = 1'b0, crc_enable = 1'b0, framing_select = 1'b1;
   logic always_report_enable = 1'b1, recover_a = 1'b0, recover_b = 1'b0, pkt_ready, chan_wb, ctl_rd, ctl_ack;
   logic ctl_wr, buf_we, desc_valid, event_valid, event_police_err, event_nospace, reca_valid, recb_valid, ev_p, ev_n;
   logic [1:0] rate_mantissa = 2'h0;
   logic [2:0] header_form = 3'h0;
   logic [3:0] rate_exponent = 4'h1, lag = 4'h0;
   logic [7:0] pkt_data = 8'h00, hdlc_address0 = 8'hA5, hdlc_address1 = 8'h7E, hdlc_control = 8'h7D, buf_data;
   logic [11:0] buffer_index = 12'hABC, ctl_index;
   logic [15:0] pkt_len = 16'h0000, pkt_seq = 16'h1234, frame_now = 16'h0100, last_frame = 16'h0000;
   logic [15:0] max_bucket_fill = 16'h0000, rx_packet_count = 16'hFFFF, next_last_frame, next_packet_count;
   logic [15:0] buf_addr, desc_addr, desc_len, room = 16'h0100, exp_wp = 16'h0000;
   logic [31:0] pkt_tstamp = 32'h89AB0001, current_bucket_level = 32'h00000000, rx_byte_count = 32'h00000010;
   logic [31:0] next_bucket_level, next_byte_count, wb_lvl, wb_bc;
   logic [47:0] rec_data, rec;
   rhdlc_stream_t stream_num = 9'h1FF, desc_stream;
   rhdlc_ptr_t ctl_base, ctl_rptr, ctl_wptr, ctl_size, ctl_new_wptr, new_wp, wb_pc, d_len, d_addr, a0;
   logic [7:0] got[$];
   int compares = 0, miscompares = 0, n_desc, n_wr, n_ev, n_a, n_b;
   rhdlc_top dut_u (.*);
   rhdlc_partner far_u (.clk(clk), .nrst(nrst), .ctl_rd(ctl_rd), .ctl_wr(ctl_wr), .ctl_new_wptr(ctl_new_wptr),
      .lag(lag), .room(room), .ctl_ack(ctl_ack), .ctl_base(ctl_base), .ctl_rptr(ctl_rptr), .ctl_wptr(ctl_wptr),
      .ctl_size(ctl_size));
   always #20 clk = ~clk;
   // ************
   // output monitor
   // ************
   // pulses stand one cycle, so the falling edge sees them settled
   always @(negedge clk) begin
      if (buf_we) begin
         if (got.size() == 0) a0 = buf_addr;
         got.push_back(buf_data);
      end
      if (desc_valid) begin n_desc++; d_len = desc_len; d_addr = desc_addr; end
      if (ctl_wr) begin n_wr++; new_wp = ctl_new_wptr; end
      if (event_valid) begin n_ev++; ev_p = event_police_err; ev_n = event_nospace; end
      if (reca_valid) n_a++;
      if (recb_valid) n_b++;
      if (reca_valid || recb_valid) rec = rec_data;
      if (chan_wb) begin wb_lvl = next_bucket_level; wb_pc = next_packet_count; wb_bc = next_byte_count; end
   end
   // ************
   // shared tasks
   // ************
   task automatic summarize();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // bytes left unconsumed by a drop are abandoned once the event shows
   task automatic run(input logic [7:0] p[$]);
      int i = 0;
      int t = 0;
      got.delete();
      {n_desc, n_wr, n_ev, n_a, n_b} = '0;
      pkt_len = 16'(p.size());
      while (n_ev == 0 && t < 400) begin
         @(negedge clk);
         #1;
         pkt_valid = n_ev == 0 && i < p.size();
         pkt_data = p[i];
         pkt_last = i == p.size() - 1;
         #1;
         if (pkt_ready && pkt_valid) i++;
         t++;
      end
      pkt_valid = 1'b0;
      if (t >= 400) begin miscompares++; summarize(); end
      chk(wb_pc, 16'(rx_packet_count + 16'h0001));
      chk(wb_bc, rx_byte_count + 32'(pkt_len));
      chk(n_ev, 1);
      rx_packet_count++;
      rx_byte_count += 32'(pkt_len);
      repeat (2) @(negedge clk);
   endtask : run
   task automatic stored(input logic [15:0] n);
      chk(n_desc, 1);
      chk(d_len, n);
      chk(n_wr, 1);
      chk(new_wp, exp_wp + n);
      chk(d_addr, exp_wp);
      chk(a0, 16'h4000 + exp_wp);
      exp_wp += n;
   endtask : stored
   // ************
   // scenarios
   // ************
   task automatic s_headers();
      logic [7:0] p[$];
      logic [7:0] r[$];
      logic [7:0] e[$];
      logic [15:0] c;
      p = {8'h7E, 8'h11, 8'h7D, 8'h00};
      for (int h = 0; h < 5; h++) begin
         header_form = 3'(h);
         crc_enable = h[0];
         run(p);
         r = p;
         if (h == 3 || h == 4) r.push_front(hdlc_control);
         if (h == 2 || h == 4) r.push_front(hdlc_address1);
         if (h != 0) r.push_front(hdlc_address0);
         c = 16'hFFFF;
         foreach (r[k]) begin
            c = c ^ {8'h00, r[k]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
         end
         c = ~c;
         if (crc_enable) r = {r, c[7:0], c[15:8]};
         e = {};
         foreach (r[k]) e = (r[k] == 8'h7E || r[k] == 8'h7D) ? {e, 8'h7D, r[k] ^ 8'h20} : {e, r[k]};
         chk(got.size(), e.size());
         foreach (e[k]) chk(got[k], e[k]);
         stored(16'(e.size()));
      end
   endtask : s_headers
   task automatic s_bit_stuff();
      framing_select = 1'b0;
      {header_form, crc_enable, recover_a, recover_b} = {3'h0, 3'h3};
      run({8'hFF, 8'hFF, 8'hFF, 8'hFF});
      chk(got.size(), 5);
      chk(got[0], 8'hDF);
      stored(16'h0005);
      chk(n_a, 1);
      chk(n_b, 1);
      chk(rec, {pkt_seq, pkt_tstamp});
      {framing_select, recover_a, recover_b} = 3'h4;
   endtask : s_bit_stuff
   task automatic s_police();
      max_bucket_fill = 16'h0001;
      current_bucket_level = 32'h00000040;
      run({8'h01, 8'h02, 8'h03, 8'h04});
      chk(ev_p, 1'b1);
      chk(n_desc + n_wr + got.size(), 0);
      chk(wb_lvl, 32'h00000000);
      max_bucket_fill = 16'h0000;
      run({8'h01, 8'h02, 8'h03, 8'h04});
      chk(ev_p, 1'b0);
      chk(wb_lvl, 32'h00000100);
      stored(16'h0004);
      current_bucket_level = 32'h00000000;
   endtask : s_police
   task automatic s_nospace();
      room = 16'h0004;
      lag = 4'h5;
      run({8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
      chk(ev_n, 1'b1);
      chk(n_desc + n_wr + got.size(), 0);
      room = 16'h0100;
      lag = 4'h0;
   endtask : s_nospace
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      s_headers();
      s_bit_stuff();
      s_police();
      s_nospace();
      summarize();
   end
endmodule : rhdlc_top_tb_top
`default_nettype wire
